// [hdl/motion_limit_monitor.sv]
// axis limit monitor: end switches, home switch qualification, software position bounds
`timescale 1ns/1ps
module motion_limit_monitor #(
  parameter logic signed [31:0] USR_MIN  = 32'h80000000,
  parameter logic signed [31:0] USR_MAX  = 32'h7FFFFFFF,
  parameter int                 CTRL_DIV = motion_limit_pkg::CTRL_DIV
) (
  // clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_n_i,
  // switch pins: end switches active when triggered after wiring, home pin level set by the home polarity
  input  wire logic                    positive_end_switch_input_i,
  input  wire logic                    negative_end_switch_input_i,
  input  wire logic                    home_switch_input_i,
  // drive state from the motion controller
  input  wire logic                    power_stage_en_i,
  input  wire logic                    zero_point_valid_i,
  input  wire motion_limit_pkg::mode_t op_mode_i,
  input  wire logic                    homing_toward_switch_i,
  input  wire logic                    moving_pos_i,
  input  wire logic                    moving_neg_i,
  input  wire logic signed [31:0]      actual_pos_i,
  input  wire logic [1:0]              quick_stop_reaction_i,
  input  wire logic                    fault_reset_i,
  // movement start from the position generator
  input  wire logic                    move_start_i,
  input  wire logic signed [31:0]      move_target_i,
  // fieldbus parameter port
  input  wire logic [11:0]             par_addr_i,
  input  wire logic [31:0]             par_wdata_i,
  input  wire logic                    par_wr_i,
  input  wire logic                    par_rd_i,
  output logic [31:0]                  par_rdata_o,
  output logic                         par_ack_o,
  output logic                         par_err_o,
  // reactions
  output logic                         quick_stop_o,
  output logic [1:0]                   quick_stop_mode_o,
  output logic                         error_class1_o,
  output logic                         error_event_o,
  output logic                         block_pos_o,
  output logic                         block_neg_o,
  output logic                         home_detect_o,
  // accepted movement
  output logic                         move_go_o,
  output logic signed [31:0]           move_target_o
);

  localparam int DIV_W = $clog2(CTRL_DIV + 1);

  function automatic logic signed [31:0] clamp_pos(input logic signed [31:0] v,
                                                   input logic signed [31:0] lo,
                                                   input logic signed [31:0] hi);
    logic signed [31:0] r;
    r = v;
    if (v > hi) begin
      r = hi;
    end else if (v < lo) begin
      r = lo;
    end
    return r;
  endfunction

  // parameter registers as written and as applied
  logic [1:0]         sel_r;
  logic [1:0]         sup_r;
  logic [1:0]         pol_r;
  logic signed [31:0] upper_r;
  logic signed [31:0] lower_r;
  logic [1:0]         pol_act_r;
  logic signed [31:0] upper_act_r;
  logic signed [31:0] lower_act_r;
  logic               pwr_d_r;

  // control cycle divider and samples
  logic [DIV_W-1:0]   div_cnt_r;
  logic               tick_r;
  logic               sw_pos_s_r;
  logic               sw_neg_s_r;
  logic               home_s_r;
  logic signed [31:0] pos_s_r;

  // limit state
  logic               limit_pos_r;
  logic               limit_neg_r;

  logic [2:0]         pins_sync;

  pin_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin_i     ({home_switch_input_i, negative_end_switch_input_i, positive_end_switch_input_i}),
    .level_o   (pins_sync)
  );

  // parameter decode
  wire hit_sel   = par_addr_i == motion_limit_pkg::ADDR_SOFT_SEL;
  wire hit_upper = par_addr_i == motion_limit_pkg::ADDR_SOFT_UPPER;
  wire hit_lower = par_addr_i == motion_limit_pkg::ADDR_SOFT_LOWER;
  wire hit_pol   = par_addr_i == motion_limit_pkg::ADDR_HOME_POL;
  wire hit_sup   = par_addr_i == motion_limit_pkg::ADDR_SUPPRESS;
  wire hit_any   = hit_sel | hit_upper | hit_lower | hit_pol | hit_sup;

  wire field_ok  = par_wdata_i[15:0] <= motion_limit_pkg::FIELD_MAX;
  wire sel_zero  = par_wdata_i[1:0] == motion_limit_pkg::SEL_RST;
  wire pol_ok    = (par_wdata_i[1:0] == motion_limit_pkg::POL_NC || par_wdata_i[1:0] == motion_limit_pkg::POL_NO)
                   && par_wdata_i[15:2] == 14'h0000;
  wire sel_wr_ok = field_ok && (sel_zero || zero_point_valid_i);
  wire pol_wr_ok = pol_ok && !power_stage_en_i;
  wire bnd_wr_ok = !power_stage_en_i;

  wire wr_ok     = (hit_sel && sel_wr_ok) || (hit_sup && field_ok) || (hit_pol && pol_wr_ok)
                   || ((hit_upper || hit_lower) && bnd_wr_ok);
  wire do_wr     = par_wr_i && wr_ok;
  wire bad_wr    = par_wr_i && !wr_ok;
  wire bad_rd    = par_rd_i && !par_wr_i && !hit_any;

  wire signed [31:0] wr_bound = clamp_pos($signed(par_wdata_i), USR_MIN, USR_MAX);

  wire [31:0] rd_mux = hit_sel   ? {30'h00000000, sel_r} :
                       hit_sup   ? {30'h00000000, sup_r} :
                       hit_pol   ? {30'h00000000, pol_r} :
                       hit_upper ? upper_r :
                       hit_lower ? lower_r : 32'h00000000;

  // switch and bound evaluation
  wire pwr_rise   = power_stage_en_i && !pwr_d_r;
  wire sw_mon     = zero_point_valid_i;
  wire hw_pos_hit = sw_pos_s_r && !sup_r[motion_limit_pkg::BIT_POS];
  wire hw_neg_hit = sw_neg_s_r && !sup_r[motion_limit_pkg::BIT_NEG];
  wire sb_pos_en  = sw_mon && sel_r[motion_limit_pkg::BIT_POS];
  wire sb_neg_en  = sw_mon && sel_r[motion_limit_pkg::BIT_NEG];
  wire sb_pos_hit = sb_pos_en && (pos_s_r >= upper_act_r);
  wire sb_neg_hit = sb_neg_en && (pos_s_r <= lower_act_r);
  wire pos_hit    = hw_pos_hit || sb_pos_hit;
  wire neg_hit    = hw_neg_hit || sb_neg_hit;

  wire new_pos    = pos_hit && !limit_pos_r;
  wire new_neg    = neg_hit && !limit_neg_r;
  wire again_pos  = limit_pos_r && moving_pos_i;
  wire again_neg  = limit_neg_r && moving_neg_i;
  wire violation  = tick_r && (new_pos || new_neg || again_pos || again_neg);

  // home switch: level by polarity, seen only while homing toward it
  wire home_level = (pol_act_r == motion_limit_pkg::POL_NC) ? !home_s_r : home_s_r;
  wire home_qual  = op_mode_i == motion_limit_pkg::MODE_HOMING && homing_toward_switch_i;

  // target check for step jog and profile position
  wire signed [31:0] chk_hi  = sb_pos_en ? upper_act_r : USR_MAX;
  wire signed [31:0] chk_lo  = sb_neg_en ? lower_act_r : USR_MIN;
  wire signed [31:0] tgt_nxt = (op_mode_i == motion_limit_pkg::MODE_TGT_CHECK)
                               ? clamp_pos(move_target_i, chk_lo, chk_hi)
                               : move_target_i;

  // parameter port
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      par_rdata_o <= 32'h00000000;
      par_ack_o   <= 1'b0;
      par_err_o   <= 1'b0;
    end else begin
      par_ack_o   <= (par_wr_i && wr_ok) || (par_rd_i && !par_wr_i && hit_any);
      par_err_o   <= bad_wr || bad_rd;
      if (par_rd_i && !par_wr_i) begin
        par_rdata_o <= rd_mux;
      end
    end
  end

  // written settings
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sel_r   <= motion_limit_pkg::SEL_RST;
      sup_r   <= motion_limit_pkg::SUP_RST;
      pol_r   <= motion_limit_pkg::POL_RST;
      upper_r <= motion_limit_pkg::UPPER_RST;
      lower_r <= motion_limit_pkg::LOWER_RST;
    end else if (do_wr) begin
      if (hit_sel) begin
        sel_r <= par_wdata_i[1:0];
      end
      if (hit_sup) begin
        sup_r <= par_wdata_i[1:0];
      end
      if (hit_pol) begin
        pol_r <= par_wdata_i[1:0];
      end
      if (hit_upper) begin
        upper_r <= wr_bound;
      end
      if (hit_lower) begin
        lower_r <= wr_bound;
      end
    end
  end

  // applied copies change only as the power stage comes on
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pwr_d_r     <= 1'b0;
      pol_act_r   <= motion_limit_pkg::POL_RST;
      upper_act_r <= motion_limit_pkg::UPPER_RST;
      lower_act_r <= motion_limit_pkg::LOWER_RST;
    end else begin
      pwr_d_r <= power_stage_en_i;
      if (pwr_rise) begin
        pol_act_r   <= pol_r;
        upper_act_r <= upper_r;
        lower_act_r <= lower_r;
      end
    end
  end

  // control cycle enable
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      div_cnt_r <= '0;
      tick_r    <= 1'b0;
    end else if (div_cnt_r == DIV_W'(CTRL_DIV - 1)) begin
      div_cnt_r <= '0;
      tick_r    <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_r + DIV_W'(1);
      tick_r    <= 1'b0;
    end
  end

  // one sample of switches and position per control cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sw_pos_s_r <= 1'b0;
      sw_neg_s_r <= 1'b0;
      home_s_r   <= 1'b0;
      pos_s_r    <= 32'h00000000;
    end else if (div_cnt_r == DIV_W'(CTRL_DIV - 1)) begin
      sw_pos_s_r <= pins_sync[0];
      sw_neg_s_r <= pins_sync[1];
      home_s_r   <= pins_sync[2];
      pos_s_r    <= actual_pos_i;
    end
  end

  // latched limit side; released once the axis has left the limit
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      limit_pos_r <= 1'b0;
      limit_neg_r <= 1'b0;
    end else if (tick_r) begin
      limit_pos_r <= pos_hit;
      limit_neg_r <= neg_hit;
    end
  end

  // error and quick stop; a violation in the fault reset cycle wins
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      error_class1_o <= 1'b0;
      quick_stop_o   <= 1'b0;
      error_event_o  <= 1'b0;
    end else begin
      error_event_o <= violation;
      if (violation) begin
        error_class1_o <= 1'b1;
        quick_stop_o   <= 1'b1;
      end else if (fault_reset_i) begin
        error_class1_o <= 1'b0;
        quick_stop_o   <= 1'b0;
      end
    end
  end

  // direction blocks, reaction selector, home detection
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      block_pos_o       <= 1'b0;
      block_neg_o       <= 1'b0;
      quick_stop_mode_o <= 2'h0;
      home_detect_o     <= 1'b0;
    end else begin
      block_pos_o       <= limit_pos_r;
      block_neg_o       <= limit_neg_r;
      quick_stop_mode_o <= quick_stop_reaction_i;
      home_detect_o     <= home_qual && home_level;
    end
  end

  // movement start: free modes pass the target, checked modes clamp it
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      move_go_o     <= 1'b0;
      move_target_o <= 32'h00000000;
    end else begin
      move_go_o <= move_start_i;
      if (move_start_i) begin
        move_target_o <= tgt_nxt;
      end
    end
  end

endmodule

// [hdl/motion_limit_pkg.sv]
// constants, parameter map and mode type shared by the motion limit monitor
package motion_limit_pkg;

  // parameter addresses on the fieldbus parameter port
  localparam logic [11:0] ADDR_SOFT_SEL   = 12'h606;
  localparam logic [11:0] ADDR_SOFT_UPPER = 12'h608;
  localparam logic [11:0] ADDR_SOFT_LOWER = 12'h60A;
  localparam logic [11:0] ADDR_HOME_POL   = 12'h61C;
  localparam logic [11:0] ADDR_SUPPRESS   = 12'h64A;

  // reset values
  localparam logic [1:0]         SEL_RST   = 2'h0;
  localparam logic [1:0]         SUP_RST   = 2'h0;
  localparam logic [1:0]         POL_RST   = 2'h1;
  localparam logic signed [31:0] UPPER_RST = 32'h7FFFFFFF;
  localparam logic signed [31:0] LOWER_RST = 32'h80000000;

  // two-bit selector fields: bit 0 positive side, bit 1 negative side
  localparam int               BIT_POS   = 0;
  localparam int               BIT_NEG   = 1;
  localparam logic [15:0]      FIELD_MAX = 16'h0003;
  localparam logic [1:0]       POL_NC    = 2'h1;
  localparam logic [1:0]       POL_NO    = 2'h2;

  // control cycle timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int CTRL_CYCLE_NS  = 1000;
  localparam int CTRL_DIV       = (CTRL_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // operating mode classes as seen by the limit monitor
  typedef enum logic [2:0] {
    MODE_IDLE,
    MODE_HOMING,
    MODE_TGT_FREE,
    MODE_TGT_CHECK,
    MODE_NO_TGT
  } mode_t;

endpackage

// [hdl/pin_sync.sv]
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  // pins and synchronised levels
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] meta_r;

  // the first stage feeds only the second stage
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      meta_r  <= '0;
      level_o <= '0;
    end else begin
      meta_r  <= pin_i;
      level_o <= meta_r;
    end
  end

endmodule

// [testbench/axis_switch_model.sv]
// axis model: end switches and a normally closed home cam placed along the travel
`timescale 1ns/1ps
module axis_switch_model (
  // axis position
  input  wire logic signed [31:0] pos_i,
  // switch pins
  output logic                    pos_sw_o,
  output logic                    neg_sw_o,
  output logic                    home_sw_o
);
  assign pos_sw_o  = (pos_i >= 32'sh5DC);
  assign neg_sw_o  = (pos_i <= -32'sh5DC);
  // contact opens on the cam, so the pin is low at home
  assign home_sw_o = !((pos_i <= 32'shA) && (pos_i >= -32'shA));
endmodule

// [testbench/motion_limit_monitor_sva.sv]
// port assertions for the motion limit monitor
`timescale 1ns/1ps
module motion_limit_monitor_sva (
  // clock and reset
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  // watched inputs
  input wire logic [1:0] quick_stop_reaction_i,
  input wire logic       fault_reset_i,
  input wire logic       move_start_i,
  input wire logic       par_wr_i,
  input wire logic       par_rd_i,
  // watched outputs
  input wire logic       par_ack_o,
  input wire logic       par_err_o,
  input wire logic       quick_stop_o,
  input wire logic [1:0] quick_stop_mode_o,
  input wire logic       error_class1_o,
  input wire logic       error_event_o,
  input wire logic       block_pos_o,
  input wire logic       block_neg_o,
  input wire logic       move_go_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  chk_par_answer: assert property ((par_wr_i || par_rd_i) |=> (par_ack_o != par_err_o))
    else $error("access not answered once");
  chk_par_quiet: assert property (!(par_wr_i || par_rd_i) |=> !(par_ack_o || par_err_o))
    else $error("answer without access");
  chk_move_answer: assert property (move_start_i |=> move_go_o)
    else $error("start not answered");
  chk_event_stops: assert property (error_event_o |-> error_class1_o && quick_stop_o)
    else $error("event without stop");
  chk_error_holds: assert property (error_class1_o && !fault_reset_i |=> error_class1_o && quick_stop_o)
    else $error("error dropped early");
  chk_event_blocks: assert property (error_event_o |=> (block_pos_o || block_neg_o))
    else $error("no direction block");
  chk_event_pulse: assert property (error_event_o |=> !error_event_o)
    else $error("event too long");
  chk_qs_mode: assert property ($past(rst_n_i) |-> quick_stop_mode_o == $past(quick_stop_reaction_i))
    else $error("stop mode mismatch");
endmodule
bind motion_limit_monitor motion_limit_monitor_sva i_sva (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .quick_stop_reaction_i(quick_stop_reaction_i),
  .fault_reset_i(fault_reset_i), .move_start_i(move_start_i), .par_wr_i(par_wr_i), .par_rd_i(par_rd_i),
  .par_ack_o(par_ack_o), .par_err_o(par_err_o), .quick_stop_o(quick_stop_o), .error_event_o(error_event_o),
  .quick_stop_mode_o(quick_stop_mode_o), .error_class1_o(error_class1_o), .block_pos_o(block_pos_o),
  .block_neg_o(block_neg_o), .move_go_o(move_go_o));

// [testbench/test_motion_limit_monitor.sv]
// self-checking bench for the motion limit monitor
`timescale 1ns/1ps
module test_motion_limit_monitor;
  localparam logic signed [31:0] UMAX = 32'sh3E8;
  logic                    clk_sys_i, rst_n_i, psw, nsw, hsw, pwr, zok, tow, mvp, mvn, frst, start, wr, rd;
  logic                    ack, err, qs, err1, evt, blkp, blkn, home, go;
  logic [1:0]              qsr, qsm;
  logic [11:0]             addr;
  logic [11:0]             ra [5];
  logic [31:0]             wdata, rdata, rdv;
  logic signed [31:0]      pos, tgt, tgto, v;
  motion_limit_pkg::mode_t mode;
  int                      mismatches, num_checks, cycles;
  axis_switch_model i_axis (.pos_i(pos), .pos_sw_o(psw), .neg_sw_o(nsw), .home_sw_o(hsw));
  motion_limit_monitor #(.USR_MIN(-UMAX), .USR_MAX(UMAX), .CTRL_DIV(4)) i_dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .positive_end_switch_input_i(psw),
    .negative_end_switch_input_i(nsw), .home_switch_input_i(hsw), .power_stage_en_i(pwr),
    .zero_point_valid_i(zok), .op_mode_i(mode), .homing_toward_switch_i(tow), .moving_pos_i(mvp),
    .moving_neg_i(mvn), .actual_pos_i(pos), .quick_stop_reaction_i(qsr), .fault_reset_i(frst),
    .move_start_i(start), .move_target_i(tgt), .par_addr_i(addr), .par_wdata_i(wdata), .par_wr_i(wr),
    .par_rd_i(rd), .par_rdata_o(rdata), .par_ack_o(ack), .par_err_o(err), .quick_stop_o(qs),
    .quick_stop_mode_o(qsm), .error_class1_o(err1), .error_event_o(evt), .block_pos_o(blkp),
    .block_neg_o(blkn), .home_detect_o(home), .move_go_o(go), .move_target_o(tgto));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      test_done();
    end
  end
  // bounds land inside the user range
  function automatic logic [31:0] clamp(input logic signed [31:0] x, input logic signed [31:0] lim);
    return (x > lim) ? lim : (x < -lim) ? -lim : x;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
    @(posedge clk_sys_i);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys_i);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    chk(err, e);
    chk(ack, !e);
    rdv = rdata;
  endtask
  task automatic launch(input motion_limit_pkg::mode_t m, input logic signed [31:0] t, input logic [31:0] e);
    @(posedge clk_sys_i);
    mode <= m;
    tgt <= t;
    start <= 1'b1;
    @(posedge clk_sys_i);
    start <= 1'b0;
    #1;
    chk(go, 1'b1);
    chk(tgto, e);
  endtask
  // drive toward p, count violations, retreat and clear
  task automatic probe(input logic signed [31:0] p, input logic e);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    mode <= motion_limit_pkg::MODE_NO_TGT;
    pos <= p;
    mvp <= (p > 0);
    mvn <= (p < 0);
    qsr <= 2'($urandom_range(3));
    repeat (24) begin
      @(posedge clk_sys_i);
      #1;
      n += (evt === 1'b1);
    end
    chk(n > 1, e);
    chk(n == 0, !e);
    chk(qs, e);
    chk(qsm, qsr);
    chk((p > 0) ? blkp : blkn, e);
    @(posedge clk_sys_i);
    {pos, mvp, mvn} <= '0;
    repeat (12) @(posedge clk_sys_i);
    frst <= 1'b1;
    @(posedge clk_sys_i);
    frst <= 1'b0;
    #1;
    chk(err1 | qs, 1'b0);
  endtask
  initial begin
    ra = '{motion_limit_pkg::ADDR_SOFT_SEL, motion_limit_pkg::ADDR_SOFT_UPPER, motion_limit_pkg::ADDR_SOFT_LOWER,
           motion_limit_pkg::ADDR_HOME_POL, motion_limit_pkg::ADDR_SUPPRESS};
    {rst_n_i, pwr, zok, tow, mvp, mvn, frst, start, wr, rd, pos, tgt, wdata, addr, qsr} = '0;
    mode = motion_limit_pkg::MODE_IDLE;
    void'($urandom(32'hAF8A));
    // reset is synchronous, so it must cover clock edges
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      access(1'b0, ra[i], 32'h0, 1'b0);
      chk(rdv, (i == 1) ? 32'h7FFFFFFF : (i == 2) ? 32'h80000000 : (i == 3) ? 32'h1 : 32'h0);
    end
    access(1'b0, 12'h600, 32'h0, 1'b1);
    access(1'b1, ra[0], 32'h1, 1'b1);
    access(1'b1, ra[4], 32'h4, 1'b1);
    access(1'b1, ra[3], 32'h3, 1'b1);
    access(1'b1, ra[3], 32'h2, 1'b0);
    access(1'b0, ra[3], 32'h0, 1'b0);
    chk(rdv, 32'h2);
    access(1'b1, ra[3], 32'h1, 1'b0);
    for (int i = 0; i < 6; i++) begin
      v = (i < 2) ? (i ? -32'sh1388 : 32'sh1388) : 32'($urandom_range(2500)) - 32'sh4E2;
      access(1'b1, ra[1 + i[0]], v, 1'b0);
      access(1'b0, ra[1 + i[0]], 32'h0, 1'b0);
      chk(rdv, clamp(v, UMAX));
    end
    access(1'b1, ra[1], 32'h1F4, 1'b0);
    access(1'b1, ra[2], -32'sh1F4, 1'b0);
    @(posedge clk_sys_i);
    pwr <= 1'b1;
    zok <= 1'b1;
    access(1'b1, ra[1], 32'h64, 1'b1);
    access(1'b1, ra[3], 32'h2, 1'b1);
    access(1'b1, ra[0], 32'h3, 1'b0);
    launch(motion_limit_pkg::MODE_TGT_CHECK, 32'sh384, 32'h1F4);
    launch(motion_limit_pkg::MODE_TGT_CHECK, -32'sh384, -32'sh1F4);
    launch(motion_limit_pkg::MODE_TGT_FREE, 32'sh384, 32'sh384);
    v = 32'($urandom_range(2000)) - 32'sh3E8;
    launch(motion_limit_pkg::MODE_TGT_CHECK, v, clamp(v, 32'sh1F4));
    for (int s = 0; s < 4; s++) begin
      access(1'b1, ra[0], 32'(s), 1'b0);
      probe(32'sh258, s[0]);
      probe(-32'sh258, s[1]);
    end
    access(1'b1, ra[0], 32'h0, 1'b0);
    for (int s = 0; s < 4; s++) begin
      access(1'b1, ra[4], 32'(s), 1'b0);
      probe(32'sh640, !s[0]);
      probe(-32'sh640, !s[1]);
    end
    @(posedge clk_sys_i);
    mode <= motion_limit_pkg::MODE_HOMING;
    tow <= 1'b1;
    repeat (12) @(posedge clk_sys_i);
    #1;
    chk(home, 1'b1);
    @(posedge clk_sys_i);
    tow <= 1'b0;
    repeat (12) @(posedge clk_sys_i);
    #1;
    chk(home, 1'b0);
    // normally open polarity: pending while unpowered, applied on the next enable
    @(posedge clk_sys_i);
    pwr <= 1'b0;
    tow <= 1'b1;
    access(1'b1, ra[3], 32'h2, 1'b0);
    repeat (12) @(posedge clk_sys_i);
    #1;
    chk(home, 1'b1);
    @(posedge clk_sys_i);
    pwr <= 1'b1;
    repeat (12) @(posedge clk_sys_i);
    #1;
    chk(home, 1'b0);
    @(posedge clk_sys_i);
    pos <= 32'sh64;
    repeat (12) @(posedge clk_sys_i);
    #1;
    chk(home, 1'b1);
    test_done();
  end
endmodule
